// >>> rtl/hgkcr_regs.sv
module hgkcr_regs #(
  // Arbitrary neutral identification value
  parameter logic [7:0] CHIP_ID = 8'h5A,
  // Arbitrary revision value
  parameter logic [7:0] SILICON_REV = 8'h01
) (
  // Clock and resets
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic host_domain_reset_n_i,
  // Index and data port
  input wire logic index_wr_i,
  input wire logic data_wr_i,
  input wire logic data_rd_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  output logic rdata_valid_o,
  // Activation power domain select
  input wire logic kbd_power_select_i,
  // Keyboard and mouse pins
  input wire logic keyboard_clock_pin_i,
  input wire logic keyboard_data_pin_i,
  input wire logic mouse_clock_pin_i,
  input wire logic mouse_data_pin_i,
  output logic keyboard_clock_pin_o,
  output logic keyboard_clock_pin_oe_o,
  output logic keyboard_data_pin_o,
  output logic keyboard_data_pin_oe_o,
  output logic mouse_clock_pin_o,
  output logic mouse_clock_pin_oe_o,
  output logic mouse_data_pin_o,
  output logic mouse_data_pin_oe_o,
  // Controller core side
  output logic core_kbd_clock_o,
  output logic core_kbd_data_o,
  output logic core_mouse_clock_o,
  output logic core_mouse_data_o,
  input wire logic core_kbd_clock_low_i,
  input wire logic core_kbd_data_low_i,
  input wire logic core_mouse_clock_low_i,
  input wire logic core_mouse_data_low_i,
  input wire logic keyboard_interrupt_i,
  input wire logic mouse_interrupt_i,
  input wire logic kbd_irq_latch_clear_i,
  input wire logic mouse_irq_latch_clear_i,
  output logic keyboard_interrupt_o,
  output logic mouse_interrupt_o,
  output logic core_reset_o,
  // Wake logic
  output logic kbd_wake_data_o,
  output logic mouse_wake_data_o,
  // Global controls
  output logic serirq_enable_o,
  output logic fast_gate_port_enable_o,
  output logic kbd_active_o
);
  import hgkcr_pkg::*;

  // ==========================================
  // Decode helpers
  function automatic logic is_ld_index(input logic [7:0] idx);
    is_ld_index = (idx >= IDX_LD_FIRST);
  endfunction

  function automatic logic kbd_hit(input logic [7:0] idx, input logic [7:0] ldn,
                                   input logic [7:0] target);
    kbd_hit = is_ld_index(idx) && (ldn == LDN_KBD) && (idx == target);
  endfunction

  // ==========================================
  // Pin synchronisers
  logic [1:0] host_rst_sync_reg;
  logic [1:0] pwr_sync_reg;
  logic [1:0] keyboard_clock_pin_sync_reg;
  logic [1:0] keyboard_data_pin_sync_reg;
  logic [1:0] mclk_sync_reg;
  logic [1:0] mouse_data_pin_sync_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      host_rst_sync_reg <= 2'h0;
    end else begin
      host_rst_sync_reg <= {host_rst_sync_reg[0], host_domain_reset_n_i};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwr_sync_reg <= 2'h0;
      keyboard_clock_pin_sync_reg <= 2'h3;
      keyboard_data_pin_sync_reg <= 2'h3;
      mclk_sync_reg <= 2'h3;
      mouse_data_pin_sync_reg <= 2'h3;
    end else begin
      pwr_sync_reg <= {pwr_sync_reg[0], kbd_power_select_i};
      keyboard_clock_pin_sync_reg <= {keyboard_clock_pin_sync_reg[0], keyboard_clock_pin_i};
      keyboard_data_pin_sync_reg <= {keyboard_data_pin_sync_reg[0], keyboard_data_pin_i};
      mclk_sync_reg <= {mclk_sync_reg[0], mouse_clock_pin_i};
      mouse_data_pin_sync_reg <= {mouse_data_pin_sync_reg[0], mouse_data_pin_i};
    end
  end

  logic host_rst;
  logic keyboard_clock_pin_s;
  logic keyboard_data_pin_s;
  logic mclk_s;
  logic mouse_data_pin_s;
  assign host_rst = rst_i | ~host_rst_sync_reg[1];
  assign keyboard_clock_pin_s = keyboard_clock_pin_sync_reg[1];
  assign keyboard_data_pin_s = keyboard_data_pin_sync_reg[1];
  assign mclk_s = mclk_sync_reg[1];
  assign mouse_data_pin_s = mouse_data_pin_sync_reg[1];

  // ==========================================
  // Index port
  logic [7:0] index_reg;

  always_ff @(posedge clk_i) begin
    if (host_rst) begin
      index_reg <= INDEX_RESET;
    end else if (index_wr_i) begin
      index_reg <= wdata_i;
    end
  end

  // ==========================================
  // Global registers
  logic [7:0] ldn_reg;
  logic [7:0] mode_reg;

  always_ff @(posedge clk_i) begin
    if (host_rst) begin
      ldn_reg <= LDN_RESET;
    end else if (data_wr_i && index_reg == IDX_LDN) begin
      ldn_reg <= wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (host_rst) begin
      mode_reg <= MODE_RESET;
    end else if (data_wr_i && index_reg == IDX_MODE) begin
      mode_reg <= wdata_i & MODE_MASK;
    end
  end

  // ==========================================
  // Keyboard device registers
  logic [7:0] act_reg;
  logic [7:0] opt_reg;
  logic [7:0] swap_reg;
  logic [7:0] core_rst_reg;
  logic act_clear;
  logic wr_act;
  logic wr_opt;
  logic wr_swap;
  logic wr_core_rst;

  assign wr_act = data_wr_i && kbd_hit(index_reg, ldn_reg, IDX_ACTIVATE);
  assign wr_opt = data_wr_i && kbd_hit(index_reg, ldn_reg, IDX_KBD_OPT);
  assign wr_swap = data_wr_i && kbd_hit(index_reg, ldn_reg, IDX_KBD_SWAP);
  assign wr_core_rst = data_wr_i && kbd_hit(index_reg, ldn_reg, IDX_KBD_RST);
  assign act_clear = pwr_sync_reg[1] ? host_rst : rst_i;

  always_ff @(posedge clk_i) begin
    if (act_clear) begin
      act_reg <= 8'h00;
    end else if (wr_act) begin
      act_reg <= wdata_i & ACT_MASK;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      opt_reg <= OPT_RESET;
    end else if (host_rst) begin
      opt_reg <= opt_reg & OPT_ISO_MASK;
    end else if (wr_opt) begin
      opt_reg <= wdata_i & OPT_MASK;
    end
  end

  always_ff @(posedge clk_i) begin
    if (host_rst) begin
      swap_reg <= SWAP_RESET;
    end else if (wr_swap) begin
      swap_reg <= wdata_i & SWAP_MASK;
    end
  end

  always_ff @(posedge clk_i) begin
    if (host_rst) begin
      core_rst_reg <= CORE_RST_RESET;
    end else if (wr_core_rst) begin
      core_rst_reg <= wdata_i & CORE_RST_MASK;
    end
  end

  // ==========================================
  // Data port read
  logic [7:0] read_next;

  always_comb begin
    read_next = 8'h00;
    if (is_ld_index(index_reg)) begin
      if (ldn_reg == LDN_KBD) begin
        case (index_reg)
          IDX_ACTIVATE: read_next = act_reg;
          IDX_KBD_OPT: read_next = opt_reg;
          IDX_KBD_SWAP: read_next = swap_reg;
          IDX_KBD_RST: read_next = core_rst_reg;
          default: read_next = 8'h00;
        endcase
      end
    end else begin
      case (index_reg)
        IDX_LDN: read_next = ldn_reg;
        IDX_CHIP_ID: read_next = CHIP_ID;
        IDX_REVISION: read_next = SILICON_REV;
        IDX_MODE: read_next = mode_reg;
        default: read_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (host_rst) begin
      rdata_o <= 8'h00;
      rdata_valid_o <= 1'b0;
    end else begin
      rdata_valid_o <= data_rd_i;
      if (data_rd_i) begin
        rdata_o <= read_next;
      end
    end
  end

  // ==========================================
  // Interrupt latches
  logic kirq_latch_reg;
  logic mirq_latch_reg;

  always_ff @(posedge clk_i) begin
    if (host_rst) begin
      kirq_latch_reg <= 1'b0;
    end else if (keyboard_interrupt_i) begin
      kirq_latch_reg <= 1'b1;
    end else if (kbd_irq_latch_clear_i) begin
      kirq_latch_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (host_rst) begin
      mirq_latch_reg <= 1'b0;
    end else if (mouse_interrupt_i) begin
      mirq_latch_reg <= 1'b1;
    end else if (mouse_irq_latch_clear_i) begin
      mirq_latch_reg <= 1'b0;
    end
  end

  logic keyboard_irq_latched_select;
  logic mouse_irq_latched_select;
  assign keyboard_irq_latched_select = opt_reg[OPT_KEYBOARD_IRQ_LATCHED_SELECT_BIT];
  assign mouse_irq_latched_select = opt_reg[OPT_MOUSE_IRQ_LATCHED_SELECT_BIT];

  always_ff @(posedge clk_i) begin
    if (host_rst) begin
      keyboard_interrupt_o <= 1'b0;
      mouse_interrupt_o <= 1'b0;
    end else begin
      keyboard_interrupt_o <= keyboard_irq_latched_select ? kirq_latch_reg
                              : (keyboard_interrupt_i & kirq_latch_reg);
      mouse_interrupt_o <= mouse_irq_latched_select ? mirq_latch_reg
                           : (mouse_interrupt_i & mirq_latch_reg);
    end
  end

  // ==========================================
  // Pin routing, swap and isolation
  logic swap;
  logic k_iso;
  logic m_iso;
  logic ck_clk;
  logic ck_dat;
  logic cm_clk;
  logic cm_dat;
  assign swap = swap_reg[SWAP_BIT];
  assign k_iso = opt_reg[OPT_KISO_BIT];
  assign m_iso = opt_reg[OPT_MISO_BIT];
  assign ck_clk = swap ? mclk_s : keyboard_clock_pin_s;
  assign ck_dat = swap ? mouse_data_pin_s : keyboard_data_pin_s;
  assign cm_clk = swap ? keyboard_clock_pin_s : mclk_s;
  assign cm_dat = swap ? keyboard_data_pin_s : mouse_data_pin_s;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      core_kbd_clock_o <= 1'b1;
      core_kbd_data_o <= 1'b1;
      core_mouse_clock_o <= 1'b1;
      core_mouse_data_o <= 1'b1;
    end else begin
      core_kbd_clock_o <= ck_clk | k_iso;
      core_kbd_data_o <= ck_dat | k_iso;
      core_mouse_clock_o <= cm_clk | m_iso;
      core_mouse_data_o <= cm_dat | m_iso;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      keyboard_clock_pin_oe_o <= 1'b0;
      keyboard_data_pin_oe_o <= 1'b0;
      mouse_clock_pin_oe_o <= 1'b0;
      mouse_data_pin_oe_o <= 1'b0;
    end else begin
      keyboard_clock_pin_oe_o <= swap ? core_mouse_clock_low_i
                                 : core_kbd_clock_low_i;
      keyboard_data_pin_oe_o <= swap ? core_mouse_data_low_i
                                : core_kbd_data_low_i;
      mouse_clock_pin_oe_o <= swap ? core_kbd_clock_low_i
                              : core_mouse_clock_low_i;
      mouse_data_pin_oe_o <= swap ? core_kbd_data_low_i
                             : core_mouse_data_low_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      keyboard_clock_pin_o <= 1'b0;
      keyboard_data_pin_o <= 1'b0;
      mouse_clock_pin_o <= 1'b0;
      mouse_data_pin_o <= 1'b0;
    end else begin
      keyboard_clock_pin_o <= 1'b0;
      keyboard_data_pin_o <= 1'b0;
      mouse_clock_pin_o <= 1'b0;
      mouse_data_pin_o <= 1'b0;
    end
  end

  // ==========================================
  // Wake paths
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      kbd_wake_data_o <= 1'b1;
      mouse_wake_data_o <= 1'b1;
    end else begin
      kbd_wake_data_o <= keyboard_data_pin_s;
      mouse_wake_data_o <= mouse_data_pin_s;
    end
  end

  // ==========================================
  // Control outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      serirq_enable_o <= MODE_RESET[MODE_SERIRQ_BIT];
      fast_gate_port_enable_o <= 1'b0;
      kbd_active_o <= 1'b0;
      core_reset_o <= 1'b0;
    end else begin
      serirq_enable_o <= mode_reg[MODE_SERIRQ_BIT];
      fast_gate_port_enable_o <= opt_reg[OPT_PORT92_BIT];
      kbd_active_o <= act_reg[ACT_BIT];
      core_reset_o <= core_rst_reg[CORE_RST_BIT];
    end
  end
endmodule

// >>> rtl/hgkcr_pkg.sv
// Function
// - Host writes index port first, then data port reaches the selected register.
// - Reserved global indices 00h-06h and 08h-1Fh ignore writes and read zero.
// - Writing index 07h picks the logical device for later device-range accesses.
// - Activation acts only on the currently selected logical device.
// - Index 20h is read-only and returns a fixed identification code.
// - Index 21h is read-only and returns the hardwired silicon revision.
// - Index 24h bit 2 enables serial interrupts, default one; other bits read zero.
// - Activation clears on system reset if power bit is 0, else host reset.
// - Option bit 6 blocks mouse clock and data into the core, not wake.
// - Option bit 5 blocks keyboard clock and data into the core, not wake.
// - Option register clears on host reset, isolation bits only on system reset.
// - Bit 4 picks mouse interrupt: raw AND latched, or latched alone.
// - Bit 3 picks keyboard interrupt: raw AND latched, or latched alone.
// - Bit 2 enables the fast gate port; clear disables it.
// - Swap register bit 0 exchanges keyboard and mouse clock and data lines.
// - Core reset register bit 0 holds the core in reset while set.
// - Swap and core reset registers return to 00h on host reset.
// - Wake paths see the raw pins regardless of isolation and swap.
package hgkcr_pkg;
  // ==========================================
  // Global indices
  localparam logic [7:0] IDX_LDN = 8'h07;
  localparam logic [7:0] IDX_CHIP_ID = 8'h20;
  localparam logic [7:0] IDX_REVISION = 8'h21;
  localparam logic [7:0] IDX_MODE = 8'h24;
  localparam logic [7:0] IDX_LD_FIRST = 8'h30;
  // ==========================================
  // Keyboard logical device
  localparam logic [7:0] LDN_KBD = 8'h01;
  localparam logic [7:0] IDX_ACTIVATE = 8'h30;
  localparam logic [7:0] IDX_KBD_OPT = 8'hF0;
  localparam logic [7:0] IDX_KBD_SWAP = 8'hF1;
  localparam logic [7:0] IDX_KBD_RST = 8'hF2;
  // ==========================================
  // Field positions
  localparam int MODE_SERIRQ_BIT = 2;
  localparam int ACT_BIT = 0;
  localparam int OPT_MISO_BIT = 6;
  localparam int OPT_KISO_BIT = 5;
  localparam int OPT_MOUSE_IRQ_LATCHED_SELECT_BIT = 4;
  localparam int OPT_KEYBOARD_IRQ_LATCHED_SELECT_BIT = 3;
  localparam int OPT_PORT92_BIT = 2;
  localparam int SWAP_BIT = 0;
  localparam int CORE_RST_BIT = 0;
  // ==========================================
  // Reset values and masks
  localparam logic [7:0] LDN_RESET = 8'h00;
  localparam logic [7:0] MODE_RESET = 8'h04;
  localparam logic [7:0] MODE_MASK = 8'h04;
  localparam logic [7:0] ACT_MASK = 8'h01;
  localparam logic [7:0] OPT_RESET = 8'h00;
  localparam logic [7:0] OPT_MASK = 8'h7F;
  localparam logic [7:0] OPT_ISO_MASK = 8'h60;
  localparam logic [7:0] SWAP_RESET = 8'h00;
  localparam logic [7:0] SWAP_MASK = 8'h03;
  localparam logic [7:0] CORE_RST_RESET = 8'h00;
  localparam logic [7:0] CORE_RST_MASK = 8'h01;
  localparam logic [7:0] INDEX_RESET = 8'h00;
endpackage

// >>> verification/hgkcr_regs_assertions.sv
module hgkcr_regs_assertions
  import hgkcr_pkg::*;
#(
  parameter logic [7:0] CHIP_ID = 8'h5A,
  parameter logic [7:0] SILICON_REV = 8'h01
) (
  // Clock and resets
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic host_domain_reset_n_i,
  // Index and data port
  input wire logic index_wr_i,
  input wire logic data_wr_i,
  input wire logic data_rd_i,
  input wire logic [7:0] wdata_i,
  input wire logic [7:0] rdata_o,
  input wire logic rdata_valid_o,
  // Pins and controls
  input wire logic keyboard_data_pin_i,
  input wire logic kbd_wake_data_o,
  input wire logic serirq_enable_o,
  input wire logic fast_gate_port_enable_o,
  input wire logic core_reset_o,
  input wire logic kbd_active_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================
  // Shadow of index and device select
  logic [7:0] idx_reg;
  logic [7:0] ldn_reg;
  logic [2:0] hold_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i || !host_domain_reset_n_i) begin
      idx_reg <= 8'h00;
      ldn_reg <= 8'h00;
    end else begin
      if (index_wr_i) idx_reg <= wdata_i;
      if (data_wr_i && idx_reg == IDX_LDN) ldn_reg <= wdata_i;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i || !host_domain_reset_n_i) hold_reg <= 3'h4;
    else if (hold_reg != 3'h0) hold_reg <= hold_reg - 3'h1;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i || hold_reg != 3'h0);
  sequence s_kbd_wr(logic [7:0] ix);
    data_wr_i && idx_reg == ix && ldn_reg == LDN_KBD;
  endsequence
  sequence s_rd(logic [7:0] ix);
    data_rd_i && idx_reg == ix;
  endsequence
  // ==========================================
  // Properties
  a_read_valid: assert property (data_rd_i |=> rdata_valid_o)
    else $error("read gave no valid pulse");
  a_valid_cause: assert property (rdata_valid_o |-> $past(data_rd_i))
    else $error("valid pulse without read");
  a_reserved_zero: assert property (data_rd_i && (idx_reg < IDX_LDN ||
    (idx_reg > IDX_LDN && idx_reg < IDX_CHIP_ID)) |=> rdata_o == 8'h00)
    else $error("reserved index read nonzero");
  a_id_read: assert property (s_rd(IDX_CHIP_ID) |=> rdata_o == CHIP_ID)
    else $error("wrong identification value");
  a_rev_read: assert property (s_rd(IDX_REVISION) |=> rdata_o == SILICON_REV)
    else $error("wrong revision value");
  a_mode_mask: assert property (s_rd(IDX_MODE) |=> (rdata_o & ~MODE_MASK) == 8'h00)
    else $error("mode reserved bits nonzero");
  a_serirq_set: assert property (data_wr_i && idx_reg == IDX_MODE |->
    ##2 serirq_enable_o == $past(wdata_i[MODE_SERIRQ_BIT], 2))
    else $error("serial interrupt enable wrong");
  a_gate_set: assert property (s_kbd_wr(IDX_KBD_OPT) |->
    ##2 fast_gate_port_enable_o == $past(wdata_i[OPT_PORT92_BIT], 2))
    else $error("fast gate enable wrong");
  a_core_reset: assert property (s_kbd_wr(IDX_KBD_RST) |->
    ##2 core_reset_o == $past(wdata_i[CORE_RST_BIT], 2))
    else $error("core reset wrong");
  a_ldn_gate: assert property (data_wr_i && idx_reg == IDX_ACTIVATE
    && ldn_reg != LDN_KBD |=> $stable(kbd_active_o)[*2])
    else $error("activation hit wrong device");
  a_wake_raw: assert property ($stable(keyboard_data_pin_i)[*4]
    |-> kbd_wake_data_o == keyboard_data_pin_i)
    else $error("wake data not raw pin");
endmodule
bind hgkcr_regs hgkcr_regs_assertions #(.CHIP_ID(CHIP_ID), .SILICON_REV(SILICON_REV)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .host_domain_reset_n_i(host_domain_reset_n_i),
  .index_wr_i(index_wr_i), .data_wr_i(data_wr_i), .data_rd_i(data_rd_i),
  .wdata_i(wdata_i), .rdata_o(rdata_o), .rdata_valid_o(rdata_valid_o),
  .keyboard_data_pin_i(keyboard_data_pin_i), .kbd_wake_data_o(kbd_wake_data_o),
  .serirq_enable_o(serirq_enable_o), .fast_gate_port_enable_o(fast_gate_port_enable_o),
  .core_reset_o(core_reset_o), .kbd_active_o(kbd_active_o));

// >>> verification/hgkcr_host_model.sv
module hgkcr_host_model (
  // Clock
  input wire logic clk_i,
  // Index and data strobes
  output logic index_wr_o,
  output logic data_wr_o,
  output logic data_rd_o,
  output logic [7:0] wdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    index_wr_o = 1'b0;
    data_wr_o = 1'b0;
    data_rd_o = 1'b0;
    wdata_o = 8'h00;
  end
  // Index first, data after; idle data inverted
  task automatic sel(input logic [7:0] ix);
    @(posedge clk_i) index_wr_o <= 1'b1;
    wdata_o <= ix;
    @(posedge clk_i) index_wr_o <= 1'b0;
    wdata_o <= ~ix;
  endtask
  task automatic wr(input logic [7:0] ix, input logic [7:0] d);
    sel(ix);
    @(posedge clk_i) data_wr_o <= 1'b1;
    wdata_o <= d;
    @(posedge clk_i) data_wr_o <= 1'b0;
    wdata_o <= ~d;
  endtask
  task automatic again();
    @(posedge clk_i) data_rd_o <= 1'b1;
    @(posedge clk_i) data_rd_o <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ix);
    sel(ix);
    again();
  endtask
endmodule

// >>> verification/tb_host_global_and_kbd_config_regs.sv
module tb_host_global_and_kbd_config_regs;
  timeunit 1ns;
  timeprecision 1ns;
  import hgkcr_pkg::*;
  localparam logic [7:0] ID = 8'h3C; // Arbitrary value
  localparam logic [7:0] REV = 8'h02; // Arbitrary value
  logic clk_i, rst_i, host_rst_n, pwr_sel;
  logic [3:0] ext, low;
  logic [1:0] irq, clr;
  wire idx_wr, d_wr, d_rd, rvalid, core_rst, serirq, fgate, active;
  wire [7:0] wdata, rdata;
  wire [3:0] oe, core, pout;
  wire [1:0] irq_o, wake;
  wire [3:0] pin = ext & ~oe;
  logic [7:0] exp_q[$];
  logic [7:0] r;
  logic [7:0] res_idx [8] = '{8'h00, 8'h03, 8'h06, 8'h08, 8'h1F, 8'h22, 8'h25, 8'h2A};
  int fails = 0, n_compared = 0;
  integer seed = 32'ha1915638;
  hgkcr_host_model host (.clk_i(clk_i), .index_wr_o(idx_wr), .data_wr_o(d_wr),
    .data_rd_o(d_rd), .wdata_o(wdata));
  hgkcr_regs #(.CHIP_ID(ID), .SILICON_REV(REV)) DUT (
    .clk_i(clk_i), .rst_i(rst_i), .host_domain_reset_n_i(host_rst_n),
    .index_wr_i(idx_wr), .data_wr_i(d_wr), .data_rd_i(d_rd), .wdata_i(wdata),
    .rdata_o(rdata), .rdata_valid_o(rvalid), .kbd_power_select_i(pwr_sel),
    .keyboard_clock_pin_i(pin[3]), .keyboard_data_pin_i(pin[2]),
    .mouse_clock_pin_i(pin[1]), .mouse_data_pin_i(pin[0]),
    .keyboard_clock_pin_o(pout[3]), .keyboard_clock_pin_oe_o(oe[3]),
    .keyboard_data_pin_o(pout[2]), .keyboard_data_pin_oe_o(oe[2]),
    .mouse_clock_pin_o(pout[1]), .mouse_clock_pin_oe_o(oe[1]),
    .mouse_data_pin_o(pout[0]), .mouse_data_pin_oe_o(oe[0]),
    .core_kbd_clock_o(core[3]), .core_kbd_data_o(core[2]),
    .core_mouse_clock_o(core[1]), .core_mouse_data_o(core[0]),
    .core_kbd_clock_low_i(low[3]), .core_kbd_data_low_i(low[2]),
    .core_mouse_clock_low_i(low[1]), .core_mouse_data_low_i(low[0]),
    .keyboard_interrupt_i(irq[1]), .mouse_interrupt_i(irq[0]),
    .kbd_irq_latch_clear_i(clr[1]), .mouse_irq_latch_clear_i(clr[0]),
    .keyboard_interrupt_o(irq_o[1]), .mouse_interrupt_o(irq_o[0]),
    .core_reset_o(core_rst), .kbd_wake_data_o(wake[1]), .mouse_wake_data_o(wake[0]),
    .serirq_enable_o(serirq), .fast_gate_port_enable_o(fgate), .kbd_active_o(active));
  // ==========================================
  // Helpers
  task chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    n_compared++;
    if (s !== e) begin
      fails++;
      $display("FAIL %s expected %h seen %h", nm, e, s);
    end
  endtask
  task rd_exp(input logic [7:0] ix, input logic [7:0] e);
    exp_q.push_back(e);
    host.rd(ix);
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task host_reset();
    host_rst_n <= 1'b0;
    cyc(3);
    host_rst_n <= 1'b1;
    cyc(4);
  endtask
  task stop_test();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ==========================================
  // Clock, monitor, watchdog
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    if (rvalid === 1'b1) chk("rdata", exp_q.pop_front(), rdata);
  end
  initial begin
    #100000;
    fails++;
    $display("watchdog expired");
    stop_test();
  end
  // ==========================================
  // Tests
  initial begin
    rst_i = 1'b1;
    host_rst_n = 1'b1;
    pwr_sel = 1'b0;
    ext = 4'hF;
    low = 4'h0;
    irq = 2'b00;
    clr = 2'b00;
    cyc(6);
    rst_i <= 1'b0;
    cyc(4);
    rd_exp(IDX_LDN, LDN_RESET);
    rd_exp(IDX_CHIP_ID, ID);
    exp_q.push_back(ID);
    host.again();
    rd_exp(IDX_REVISION, REV);
    rd_exp(IDX_MODE, MODE_RESET);
    chk("serirq", 8'h01, {7'h0, serirq});
    host.wr(IDX_LDN, LDN_KBD);
    rd_exp(IDX_KBD_OPT, OPT_RESET);
    rd_exp(IDX_KBD_SWAP, SWAP_RESET);
    rd_exp(IDX_KBD_RST, CORE_RST_RESET);
    $display("reset values done");
    foreach (res_idx[i]) begin
      r = 8'($random(seed));
      host.wr(res_idx[i], r);
      rd_exp(res_idx[i], 8'h00);
    end
    host.wr(IDX_CHIP_ID, 8'($random(seed)));
    rd_exp(IDX_CHIP_ID, ID);
    host.wr(IDX_REVISION, 8'($random(seed)));
    rd_exp(IDX_REVISION, REV);
    r = 8'($random(seed));
    host.wr(IDX_MODE, r);
    rd_exp(IDX_MODE, r & MODE_MASK);
    host.wr(IDX_MODE, 8'h00);
    cyc(3);
    chk("serirq", 8'h00, {7'h0, serirq});
    host.wr(IDX_MODE, MODE_RESET);
    $display("global registers done");
    host.wr(IDX_LDN, 8'h02);
    host.wr(IDX_ACTIVATE, 8'h01);
    host.wr(IDX_KBD_OPT, 8'h04);
    cyc(3);
    chk("gated", 8'h00, {6'h0, active, fgate});
    host.wr(IDX_LDN, LDN_KBD);
    host.wr(IDX_ACTIVATE, 8'h01);
    host.wr(IDX_KBD_OPT, 8'h04);
    host.wr(IDX_KBD_RST, 8'h01);
    cyc(3);
    chk("selected", 8'h07, {5'h0, active, fgate, core_rst});
    rd_exp(IDX_KBD_OPT, 8'h04);
    host.wr(IDX_KBD_RST, 8'h00);
    host.wr(IDX_KBD_OPT, 8'h00);
    cyc(3);
    chk("cleared", 8'h00, {6'h0, fgate, core_rst});
    $display("options done");
    irq <= 2'b11;
    cyc(5);
    chk("irq and", 8'h03, {6'h0, irq_o});
    irq <= 2'b00;
    cyc(5);
    chk("irq and", 8'h00, {6'h0, irq_o});
    host.wr(IDX_KBD_OPT, 8'h18);
    cyc(4);
    chk("irq latched", 8'h03, {6'h0, irq_o});
    clr <= 2'b11;
    cyc(1);
    clr <= 2'b00;
    cyc(4);
    chk("irq cleared", 8'h00, {6'h0, irq_o});
    host.wr(IDX_KBD_OPT, 8'h00);
    $display("interrupts done");
    ext <= 4'b1011;
    cyc(5);
    chk("core", 8'h0B, {4'h0, core});
    host.wr(IDX_KBD_OPT, 8'h20);
    cyc(5);
    chk("kbd iso", 8'h0F, {4'h0, core});
    chk("wake", 8'h01, {6'h0, wake});
    host.wr(IDX_KBD_OPT, 8'h40);
    ext <= 4'b1110;
    cyc(5);
    chk("mouse iso", 8'h0F, {4'h0, core});
    chk("wake", 8'h02, {6'h0, wake});
    host.wr(IDX_KBD_OPT, 8'h00);
    host.wr(IDX_KBD_SWAP, 8'h01);
    cyc(5);
    chk("swap in", 8'h0B, {4'h0, core});
    low <= 4'b1000;
    cyc(3);
    chk("swap out", 8'h02, {4'h0, oe});
    chk("pin out", 8'h00, {4'h0, pout});
    low <= 4'h0;
    ext <= 4'hF;
    r = 8'($random(seed)) & 8'h01;
    host.wr(IDX_KBD_SWAP, r);
    rd_exp(IDX_KBD_SWAP, r);
    $display("pins done");
    pwr_sel <= 1'b1;
    host.wr(IDX_KBD_OPT, 8'h7C);
    host.wr(IDX_KBD_SWAP, 8'h01);
    host.wr(IDX_KBD_RST, 8'h01);
    host_reset();
    chk("active", 8'h00, {7'h0, active});
    host.wr(IDX_LDN, LDN_KBD);
    rd_exp(IDX_KBD_OPT, OPT_ISO_MASK);
    rd_exp(IDX_KBD_SWAP, 8'h00);
    rd_exp(IDX_KBD_RST, 8'h00);
    rst_i <= 1'b1;
    cyc(3);
    rst_i <= 1'b0;
    cyc(4);
    host.wr(IDX_LDN, LDN_KBD);
    rd_exp(IDX_KBD_OPT, 8'h00);
    pwr_sel <= 1'b0;
    host.wr(IDX_ACTIVATE, 8'h01);
    host_reset();
    chk("active", 8'h01, {7'h0, active});
    $display("resets done");
    cyc(4);
    stop_test();
  end
endmodule
